/* rtl/pmc_top.sv */
// Purpose: Power mode controller: mode choice and stop entry/exit sequencing
// Assumes: All inputs synchronous to i_clk_sys; acks held until request drops
// Notes:   Control and status bits are plain ports
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_top
  import pmc_pkg::*;
#(
  parameter int N_MST = 2,
  parameter int N_SLV = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  input  wire logic             i_allow_very_low_power,
  input  wire logic             i_allow_very_low_leakage,
  input  wire logic             i_allow_low_leakage_stop,
  input  wire logic [2:0]       i_stop_mode_select,
  input  wire logic [1:0]       i_run_mode_select,
  input  wire logic [2:0]       i_deep_stop_submode,
  input  wire logic             i_wfi,
  input  wire logic             i_deep_sleep_request,
  input  wire logic             i_irq,
  input  wire logic             i_wakeup,
  input  wire logic             i_reset_pin,
  input  wire logic             i_debugger_enabled,
  input  wire logic             i_debug_halt,
  input  wire logic [N_MST-1:0] i_mst_ack,
  input  wire logic [N_SLV-1:0] i_slv_ack,
  input  wire logic             i_gen_ack,
  input  wire logic             i_reg_ack,
  output logic [N_MST-1:0]      o_mst_stop_req,
  output logic [N_SLV-1:0]      o_slv_stop_req,
  output logic                  o_cpu_clk_en,
  output logic                  o_bus_clk_en,
  output logic                  o_stop_in_wait,
  output logic                  o_gen_en,
  output logic                  o_reg_run,
  output logic [2:0]            o_stop_submode,
  output logic                  o_stop_aborted_flag,
  output logic [6:0]            o_power_mode_status,
  output logic                  o_run_mode_clear
);
  typedef struct packed {
    pmc_seq_t  seq;
    pmc_mode_t mode;
    pmc_mode_t target;
    logic      from_run;
    logic      aborted;
    logic      cpu_clk;
    logic      bus_clk;
    logic      gen_en;
    logic      reg_run;
    logic      siw;
    logic      pend;
    logic      rmclr;
    logic [2:0] submode;
    logic [6:0] status;
  } pmc_state_t;

  pmc_state_t r;
  pmc_state_t next_r;
  pmc_mode_t  dec_target;
  logic       dec_valid;
  logic       in_vlp;
  logic       stop_event;

  pmc_hs_if #(.N(N_MST)) mst_if ();
  pmc_hs_if #(.N(N_SLV)) slv_if ();

  assign mst_if.ack = i_mst_ack;
  assign slv_if.ack = i_slv_ack;
  assign mst_if.req = r.seq == PMC_MST_REQ || r.seq == PMC_SLV_REQ;
  assign slv_if.req = r.seq == PMC_SLV_REQ;

  pmc_hs #(.N(N_MST)) u_mst (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .hs        (mst_if.hs)
  );

  pmc_hs #(.N(N_SLV)) u_slv (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .hs        (slv_if.hs)
  );

  assign in_vlp = r.mode == PMC_M_VERY_LOW_POWER_RUN;

  pmc_decode u_dec (
    .i_in_very_low_power_run    (in_vlp),
    .i_deep       (i_deep_sleep_request),
    .i_allow_vlp  (i_allow_very_low_power),
    .i_allow_vlls (i_allow_very_low_leakage),
    .i_allow_lls  (i_allow_low_leakage_stop),
    .i_stop_sel   (i_stop_mode_select),
    .o_target     (dec_target),
    .o_valid      (dec_valid)
  );

  // Event that ends a stop; leakage modes wake only by wakeup unit or pin
  always_comb begin
    if (r.target == PMC_M_LLS || r.target == PMC_M_VLLS) begin
      stop_event = i_wakeup || i_reset_pin;
    end else begin
      stop_event = i_irq || i_reset_pin;
    end
  end

  function automatic logic [6:0] mode_code(input pmc_mode_t m);
    case (m)
      PMC_M_RUN:  mode_code = `PMC_ST_RUN;
      PMC_M_WAIT: mode_code = `PMC_ST_RUN;
      PMC_M_STOP: mode_code = `PMC_ST_STOP;
      PMC_M_VERY_LOW_POWER_RUN: mode_code = `PMC_ST_VERY_LOW_POWER_RUN;
      PMC_M_VERY_LOW_POWER_WAIT: mode_code = `PMC_ST_VERY_LOW_POWER_WAIT;
      PMC_M_VERY_LOW_POWER_STOP: mode_code = `PMC_ST_VERY_LOW_POWER_STOP;
      PMC_M_LLS:  mode_code = `PMC_ST_LLS;
      PMC_M_VLLS: mode_code = `PMC_ST_VLLS;
      default:    mode_code = `PMC_ST_RUN;
    endcase
  endfunction

  always_comb begin
    next_r       = r;
    next_r.rmclr = 1'b0;
    case (r.seq)
      PMC_IDLE: begin
        // Run mode changes
        if (r.mode == PMC_M_RUN && i_run_mode_select == `PMC_RUN_MODE_SELECT_VERY_LOW_POWER_RUN
            && i_allow_very_low_power) begin
          next_r.mode    = PMC_M_VERY_LOW_POWER_RUN;
          next_r.reg_run = 1'b0;
        end else if (r.mode == PMC_M_VERY_LOW_POWER_RUN && i_run_mode_select == `PMC_RUN_MODE_SELECT_RUN) begin
          next_r.reg_run = 1'b1;
          next_r.pend    = 1'b1;
        end
        if (r.pend && i_reg_ack) begin
          next_r.mode  = PMC_M_RUN;
          next_r.pend  = 1'b0;
          next_r.rmclr = 1'b1;
        end
        if (i_wfi && !r.pend && dec_valid) begin
          next_r.target  = dec_target;
          next_r.cpu_clk = i_debugger_enabled;
          if (dec_target == PMC_M_WAIT || dec_target == PMC_M_VERY_LOW_POWER_WAIT) begin
            next_r.mode = dec_target;
            next_r.siw  = 1'b1;
            next_r.seq  = PMC_WAITING;
          end else begin
            next_r.from_run = r.mode == PMC_M_RUN;
            next_r.aborted  = 1'b0;
            next_r.submode  = i_deep_stop_submode;
            next_r.seq      = PMC_MST_REQ;
          end
        end
      end
      PMC_WAITING: begin
        if (i_irq || (i_debugger_enabled && i_debug_halt)) begin
          next_r.mode    = r.mode == PMC_M_VERY_LOW_POWER_WAIT ? PMC_M_VERY_LOW_POWER_RUN : PMC_M_RUN;
          next_r.cpu_clk = 1'b1;
          next_r.siw     = 1'b0;
          next_r.seq     = PMC_IDLE;
        end
      end
      PMC_MST_REQ, PMC_SLV_REQ, PMC_CLK_OFF, PMC_GEN_OFF: begin
        if (i_irq || i_reset_pin) begin
          next_r.seq = PMC_ABORT;
        end else if (r.seq == PMC_MST_REQ) begin
          if (mst_if.all_ack) next_r.seq = PMC_SLV_REQ;
        end else if (r.seq == PMC_SLV_REQ) begin
          if (slv_if.all_ack) next_r.seq = PMC_CLK_OFF;
        end else if (r.seq == PMC_CLK_OFF) begin
          next_r.bus_clk = 1'b0;
          next_r.seq     = PMC_GEN_OFF;
        end else begin
          next_r.gen_en  = 1'b0;
          next_r.reg_run = 1'b0;
          next_r.seq     = PMC_REG_STOP;
        end
      end
      PMC_ABORT: begin
        next_r.aborted = 1'b1;
        next_r.bus_clk = 1'b1;
        next_r.gen_en  = 1'b1;
        next_r.cpu_clk = 1'b1;
        next_r.mode    = PMC_M_RUN;
        next_r.reg_run = 1'b1;
        next_r.rmclr   = 1'b1;
        next_r.seq     = PMC_IDLE;
      end
      PMC_REG_STOP: begin
        if (i_reg_ack) begin
          next_r.mode = r.target;
          next_r.seq  = PMC_STOPPED;
        end
      end
      PMC_STOPPED: begin
        if (stop_event || (i_debugger_enabled && i_debug_halt
            && (r.target == PMC_M_STOP || r.target == PMC_M_VERY_LOW_POWER_STOP))) begin
          next_r.reg_run = !(r.target == PMC_M_VERY_LOW_POWER_STOP && !r.from_run && !i_reset_pin);
          next_r.pend    = i_reset_pin || r.from_run || r.target != PMC_M_VERY_LOW_POWER_STOP;
          next_r.seq     = PMC_REG_RUN;
        end
      end
      PMC_REG_RUN: begin
        if (i_reg_ack || !r.reg_run) begin
          next_r.gen_en = 1'b1;
          next_r.seq    = PMC_GEN_ON;
        end
      end
      PMC_GEN_ON: begin
        if (i_gen_ack) begin
          next_r.bus_clk = 1'b1;
          next_r.seq     = PMC_CLK_ON;
        end
      end
      PMC_CLK_ON: begin
        next_r.cpu_clk = 1'b1;
        next_r.mode    = r.pend ? PMC_M_RUN : PMC_M_VERY_LOW_POWER_RUN;
        next_r.rmclr   = r.pend;
        next_r.pend    = 1'b0;
        next_r.seq     = PMC_IDLE;
      end
      default: begin
        next_r.seq = PMC_IDLE;
      end
    endcase
    next_r.status = mode_code(next_r.mode);
    if (i_debugger_enabled && (next_r.mode == PMC_M_STOP || next_r.mode == PMC_M_VERY_LOW_POWER_STOP)) begin
      next_r.status = r.status;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r         <= '0;
      r.seq     <= PMC_IDLE;
      r.mode    <= PMC_M_RUN;
      r.target  <= PMC_M_RUN;
      r.cpu_clk <= 1'b1;
      r.bus_clk <= 1'b1;
      r.gen_en  <= 1'b1;
      r.reg_run <= 1'b1;
      r.submode <= `PMC_SUBMODE_RST;
      r.status  <= `PMC_ST_RUN;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_mst_stop_req      = mst_if.stop_req;
  assign o_slv_stop_req      = slv_if.stop_req;
  assign o_cpu_clk_en        = r.cpu_clk;
  assign o_bus_clk_en        = r.bus_clk;
  assign o_stop_in_wait      = r.siw;
  assign o_gen_en            = r.gen_en;
  assign o_reg_run           = r.reg_run;
  assign o_stop_submode      = r.submode;
  assign o_stop_aborted_flag = r.aborted;
  assign o_power_mode_status = r.status;
  assign o_run_mode_clear    = r.rmclr;
endmodule // pmc_top

/* rtl/pmc_params.svh */
// Purpose: Named constants of the power mode controller
// Assumes: Included by every design file except the package and the interface
// Notes:   Definitions only
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_STOP_MODE_SELECT_NORMAL  3'h0
`define PMC_STOP_MODE_SELECT_VERY_LOW_POWER_STOP    3'h2
`define PMC_STOP_MODE_SELECT_LLS     3'h3
`define PMC_STOP_MODE_SELECT_VLLS    3'h4
`define PMC_RUN_MODE_SELECT_RUN      2'h0
`define PMC_RUN_MODE_SELECT_VERY_LOW_POWER_RUN     2'h2
`define PMC_ST_RUN        7'h01
`define PMC_ST_STOP       7'h02
`define PMC_ST_VERY_LOW_POWER_RUN       7'h04
`define PMC_ST_VERY_LOW_POWER_WAIT       7'h08
`define PMC_ST_VERY_LOW_POWER_STOP       7'h10
`define PMC_ST_LLS        7'h20
`define PMC_ST_VLLS       7'h40
`define PMC_SUBMODE_RST   3'h3
`endif

/* rtl/pmc_pkg.sv */
// Purpose: Types of the power mode controller
// Assumes: Nothing
// Notes:   Sequencer states and mode encoding
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_IDLE     = 4'b0000,
    PMC_MST_REQ  = 4'b0001,
    PMC_SLV_REQ  = 4'b0010,
    PMC_CLK_OFF  = 4'b0011,
    PMC_GEN_OFF  = 4'b0100,
    PMC_REG_STOP = 4'b0101,
    PMC_STOPPED  = 4'b0110,
    PMC_REG_RUN  = 4'b0111,
    PMC_GEN_ON   = 4'b1000,
    PMC_CLK_ON   = 4'b1001,
    PMC_WAITING  = 4'b1010,
    PMC_ABORT    = 4'b1011
  } pmc_seq_t;

  typedef enum logic [2:0] {
    PMC_M_RUN  = 3'b000,
    PMC_M_STOP = 3'b001,
    PMC_M_VERY_LOW_POWER_RUN = 3'b010,
    PMC_M_VERY_LOW_POWER_WAIT = 3'b011,
    PMC_M_VERY_LOW_POWER_STOP = 3'b100,
    PMC_M_LLS  = 3'b101,
    PMC_M_VLLS = 3'b110,
    PMC_M_WAIT = 3'b111
  } pmc_mode_t;
endpackage

/* rtl/pmc_hs_if.sv */
// Purpose: Request and acknowledge group for stop handshakes
// Assumes: One request line per party, acknowledge per party
// Notes:   Used between the sequencer and the handshake unit
`timescale 1ns/1ps
interface pmc_hs_if #(parameter int N = 4);
  logic         req;
  logic         all_ack;
  logic [N-1:0] ack;
  logic [N-1:0] stop_req;
  modport ctl (output req, input all_ack);
  modport hs  (input req, input ack, output stop_req, output all_ack);
endinterface

/* rtl/pmc_hs.sv */
// Purpose: Holds stop requests to a group of parties and gathers acks
// Assumes: Acknowledges are synchronous to the clock
// Notes:   Requests follow the group request one clock later, with or without acks
`timescale 1ns/1ps
`include "pmc_params.svh"
module pmc_hs
  import pmc_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  pmc_hs_if.hs      hs
);
  typedef struct packed {
    logic [N-1:0] stop_req;
  } pmc_hs_state_t;

  pmc_hs_state_t r;
  pmc_hs_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.stop_req = hs.req ? {N{1'b1}} : {N{1'b0}};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign hs.stop_req = r.stop_req;
  assign hs.all_ack  = r.stop_req == {N{1'b1}} && (&hs.ack);
endmodule // pmc_hs

/* rtl/pmc_decode.sv */
// Purpose: Picks the target low-power mode for a sleep request
// Assumes: Inputs are stable while the request is decoded
// Notes:   Pure combinational decode
`timescale 1ns/1ps
`include "pmc_params.svh"
module pmc_decode
  import pmc_pkg::*;
(
  input  wire logic       i_in_very_low_power_run,
  input  wire logic       i_deep,
  input  wire logic       i_allow_vlp,
  input  wire logic       i_allow_vlls,
  input  wire logic       i_allow_lls,
  input  wire logic [2:0] i_stop_sel,
  output pmc_mode_t       o_target,
  output logic            o_valid
);
  always_comb begin
    o_target = PMC_M_RUN;
    o_valid  = 1'b1;
    if (!i_deep) begin
      o_target = i_in_very_low_power_run ? PMC_M_VERY_LOW_POWER_WAIT : PMC_M_WAIT;
    end else begin
      case (i_stop_sel)
        `PMC_STOP_MODE_SELECT_NORMAL: begin
          o_target = i_in_very_low_power_run ? PMC_M_VERY_LOW_POWER_STOP : PMC_M_STOP;
        end
        `PMC_STOP_MODE_SELECT_VERY_LOW_POWER_STOP: begin
          if (i_in_very_low_power_run || i_allow_vlp) begin
            o_target = PMC_M_VERY_LOW_POWER_STOP;
          end else begin
            o_valid = 1'b0;
          end
        end
        `PMC_STOP_MODE_SELECT_LLS: begin
          o_target = PMC_M_LLS;
          o_valid  = i_allow_lls;
        end
        `PMC_STOP_MODE_SELECT_VLLS: begin
          o_target = PMC_M_VLLS;
          o_valid  = i_allow_vlls;
        end
        default: begin
          o_valid = 1'b0;
        end
      endcase
    end
  end
endmodule // pmc_decode

/* bench/pmc_top_asserts.sv */
// Purpose: Port-level timing checks of the power mode controller
// Assumes: One clock, synchronous active-high reset, clock enable held high
// Notes:   Bound into pmc_top
`timescale 1ns/1ps
`include "pmc_params.svh"
module pmc_top_asserts #(
  parameter int N_MST = 2,
  parameter int N_SLV = 4
) (
  input wire logic             i_clk_sys,
  input wire logic             i_sys_rst,
  input wire logic             i_allow_very_low_power,
  input wire logic             i_allow_very_low_leakage,
  input wire logic             i_allow_low_leakage_stop,
  input wire logic [2:0]       i_stop_mode_select,
  input wire logic [1:0]       i_run_mode_select,
  input wire logic             i_wfi,
  input wire logic             i_deep_sleep_request,
  input wire logic             i_irq,
  input wire logic             i_reset_pin,
  input wire logic             i_debugger_enabled,
  input wire logic [N_MST-1:0] i_mst_ack,
  input wire logic [N_SLV-1:0] i_slv_ack,
  input wire logic             i_reg_ack,
  input wire logic [N_MST-1:0] o_mst_stop_req,
  input wire logic [N_SLV-1:0] o_slv_stop_req,
  input wire logic             o_cpu_clk_en,
  input wire logic             o_bus_clk_en,
  input wire logic             o_gen_en,
  input wire logic             o_reg_run,
  input wire logic             o_stop_aborted_flag,
  input wire logic [6:0]       o_power_mode_status
);
  logic sel_ok;
  logic base;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Selection that a sleep request from RUN may take
  assign sel_ok = (i_stop_mode_select == `PMC_STOP_MODE_SELECT_NORMAL)
      || (i_stop_mode_select == `PMC_STOP_MODE_SELECT_VERY_LOW_POWER_STOP && i_allow_very_low_power)
      || (i_stop_mode_select == `PMC_STOP_MODE_SELECT_LLS && i_allow_low_leakage_stop)
      || (i_stop_mode_select == `PMC_STOP_MODE_SELECT_VLLS && i_allow_very_low_leakage);
  // Settled in RUN with no sequence under way
  assign base = !i_debugger_enabled && o_cpu_clk_en && o_bus_clk_en && o_reg_run
      && o_mst_stop_req == '0 && o_power_mode_status == `PMC_ST_RUN && !i_irq;

  req_held_a:
    assert property ((o_mst_stop_req & ~i_mst_ack) != '0 && !i_irq && !i_reset_pin
      |=> o_mst_stop_req == $past(o_mst_stop_req)) else $error("master request dropped");
  slv_after_mst_a:
    assert property ($rose(|o_slv_stop_req) |-> $past(&i_mst_ack))
    else $error("slave request early");
  cpu_gate_first_a:
    assert property (base && i_run_mode_select == `PMC_RUN_MODE_SELECT_RUN && i_wfi
      && (!i_deep_sleep_request || sel_ok) |=> !o_cpu_clk_en) else $error("cpu clock kept");
  bus_off_order_a:
    assert property ($fell(o_bus_clk_en) |-> $past(&i_slv_ack) || $past(&i_slv_ack, 2))
    else $error("bus clock off early");
  gen_on_order_a:
    assert property ($rose(o_gen_en) |-> $past(i_reg_ack)) else $error("generator on early");
  cpu_on_last_a:
    assert property ($rose(o_cpu_clk_en) |-> o_bus_clk_en && o_gen_en)
    else $error("cpu clock on early");
  late_wake_held_a:
    assert property (!o_gen_en && !o_reg_run && !o_bus_clk_en && !i_reg_ack
      |=> !o_gen_en && !o_stop_aborted_flag) else $error("regulator switch broken");
  very_low_power_run_entry_a:
    assert property (base && !i_wfi && i_run_mode_select == `PMC_RUN_MODE_SELECT_VERY_LOW_POWER_RUN
      && i_allow_very_low_power |=> o_power_mode_status == `PMC_ST_VERY_LOW_POWER_RUN && !o_reg_run)
    else $error("very_low_power_run not entered");
endmodule // pmc_top_asserts

bind pmc_top pmc_top_asserts #(.N_MST(N_MST), .N_SLV(N_SLV)) chk (
  .i_clk_sys, .i_sys_rst, .i_allow_very_low_power, .i_allow_very_low_leakage,
  .i_allow_low_leakage_stop, .i_stop_mode_select, .i_run_mode_select, .i_wfi,
  .i_deep_sleep_request, .i_irq, .i_reset_pin, .i_debugger_enabled, .i_mst_ack, .i_slv_ack,
  .i_reg_ack, .o_mst_stop_req, .o_slv_stop_req, .o_cpu_clk_en, .o_bus_clk_en, .o_gen_en,
  .o_reg_run, .o_stop_aborted_flag, .o_power_mode_status);

/* bench/pmc_far_model.sv */
// Purpose: Masters, slaves, clock generator and regulator facing the controller
// Assumes: Random delays from the bench seed
// Notes:   i_hold withholds master and slave acks
`timescale 1ns/1ps
module pmc_far_model #(
  parameter int N_MST = 2,
  parameter int N_SLV = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_hold,
  input  wire logic [N_MST-1:0] i_mst_stop_req,
  input  wire logic [N_SLV-1:0] i_slv_stop_req,
  input  wire logic             i_gen_en,
  input  wire logic             i_reg_run,
  output logic [N_MST-1:0]      o_mst_ack,
  output logic [N_SLV-1:0]      o_slv_ack,
  output logic                  o_gen_ack,
  output logic                  o_reg_ack
);
  logic gen_up;
  logic reg_done;
  logic reg_level;
  // Acks fall at once when the requested level changes
  assign o_gen_ack = i_gen_en & gen_up;
  assign o_reg_ack = reg_done & (i_reg_run == reg_level);
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_mst_ack <= '0;
      o_slv_ack <= '0;
      gen_up <= 1'b1;
      reg_done <= 1'b1;
      reg_level <= 1'b1;
    end else begin
      for (int i = 0; i < N_MST; i++)
        o_mst_ack[i] <= i_mst_stop_req[i] & !i_hold & (o_mst_ack[i] | ($urandom % 3 == 0));
      for (int i = 0; i < N_SLV; i++)
        o_slv_ack[i] <= i_slv_stop_req[i] & !i_hold & (o_slv_ack[i] | ($urandom % 3 == 0));
      gen_up <= i_gen_en & (gen_up | ($urandom % 4 == 0));
      reg_done <= (i_reg_run == reg_level) & (reg_done | ($urandom % 4 == 0));
      reg_level <= i_reg_run;
    end
  end
endmodule // pmc_far_model

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the power mode controller
// Assumes: Far side from pmc_far_model
// Notes:   Seeded random submodes, selections and ack delays
`timescale 1ns/1ps
`include "pmc_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  localparam int NM = 2;
  localparam int NS = 4;
  localparam logic [2:0] SEL [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  localparam logic [6:0] STS [4] = '{7'h02, 7'h10, 7'h20, 7'h40};
  localparam logic [1:0] SRC [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  int checks = 0;
  int fail_count = 0;
  int clr_n = 0;
  int snap = 0;
  logic [2:0] sub;
  logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_wfi = 1'b0, hold = 1'b0;
  logic i_deep_sleep_request = 1'b0, i_irq = 1'b0, i_wakeup = 1'b0, i_reset_pin = 1'b0;
  logic i_allow_very_low_power = 1'b1, i_allow_very_low_leakage = 1'b1;
  logic i_allow_low_leakage_stop = 1'b1, i_debugger_enabled = 1'b0, i_debug_halt = 1'b0;
  logic [2:0] i_stop_mode_select = 3'h0, i_deep_stop_submode = 3'h3, o_stop_submode;
  logic [1:0] i_run_mode_select = 2'h0;
  logic [NM-1:0] i_mst_ack, o_mst_stop_req;
  logic [NS-1:0] i_slv_ack, o_slv_stop_req;
  logic i_gen_ack, i_reg_ack, o_cpu_clk_en, o_bus_clk_en, o_stop_in_wait, o_gen_en;
  logic o_reg_run, o_stop_aborted_flag, o_run_mode_clear;
  logic [6:0] o_power_mode_status;

  pmc_top #(.N_MST(NM), .N_SLV(NS)) uut (.i_clk_sys, .i_sys_rst, .i_ce,
    .i_allow_very_low_power, .i_allow_very_low_leakage, .i_allow_low_leakage_stop,
    .i_stop_mode_select, .i_run_mode_select, .i_deep_stop_submode, .i_wfi,
    .i_deep_sleep_request, .i_irq, .i_wakeup, .i_reset_pin, .i_debugger_enabled,
    .i_debug_halt, .i_mst_ack, .i_slv_ack, .i_gen_ack, .i_reg_ack, .o_mst_stop_req,
    .o_slv_stop_req, .o_cpu_clk_en, .o_bus_clk_en, .o_stop_in_wait, .o_gen_en, .o_reg_run,
    .o_stop_submode, .o_stop_aborted_flag, .o_power_mode_status, .o_run_mode_clear);
  pmc_far_model #(.N_MST(NM), .N_SLV(NS)) far (.i_clk_sys, .i_sys_rst, .i_hold(hold),
    .i_mst_stop_req(o_mst_stop_req), .i_slv_stop_req(o_slv_stop_req), .i_gen_en(o_gen_en),
    .i_reg_run(o_reg_run), .o_mst_ack(i_mst_ack), .o_slv_ack(i_slv_ack),
    .o_gen_ack(i_gen_ack), .o_reg_ack(i_reg_ack));

  always #4 i_clk_sys = ~i_clk_sys;

  // Counts run-select clear pulses away from the launching edge
  always @(negedge i_clk_sys) begin
    if (o_run_mode_clear === 1'b1)
      clr_n++;
  end

  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic sleep(input logic deep, input logic [2:0] sel);
    @(posedge i_clk_sys);
    i_deep_sleep_request <= deep;
    i_stop_mode_select <= sel;
    i_wfi <= 1'b1;
    @(posedge i_clk_sys);
    i_wfi <= 1'b0;
  endtask

  task automatic wait_for(input logic [6:0] st, input logic cpu);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    while ((o_power_mode_status !== st || o_cpu_clk_en !== cpu) && n < 300) begin
      @(negedge i_clk_sys);
      n++;
    end
    `CHK(o_power_mode_status, st)
    `CHK(o_cpu_clk_en, cpu)
  endtask

  // Source 0 interrupt, 1 wakeup input, 2 reset pin
  task automatic wake(input logic [1:0] src, input logic [6:0] st);
    @(posedge i_clk_sys);
    i_irq <= (src == 2'h0);
    i_wakeup <= (src == 2'h1);
    i_reset_pin <= (src == 2'h2);
    wait_for(st, 1'b1);
    @(posedge i_clk_sys);
    i_irq <= 1'b0;
    i_wakeup <= 1'b0;
    i_reset_pin <= 1'b0;
  endtask

  initial begin
    void'($urandom(91));
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(o_power_mode_status, `PMC_ST_RUN)
    for (int k = 0; k < 4; k++) begin
      sub = 3'($urandom_range(0, 3));
      @(posedge i_clk_sys);
      i_deep_stop_submode <= sub;
      sleep(1'b1, SEL[k]);
      wait_for(STS[k], 1'b0);
      if (k == 3)
        `CHK(o_stop_submode, sub)
      wake(SRC[k], `PMC_ST_RUN);
    end
    @(posedge i_clk_sys);
    i_allow_very_low_power <= 1'b0;
    sleep(1'b1, `PMC_STOP_MODE_SELECT_VERY_LOW_POWER_STOP);
    sleep(1'b1, 3'(5 + $urandom_range(0, 2)));
    repeat (3) @(negedge i_clk_sys);
    `CHK(o_cpu_clk_en, 1'b1)
    `CHK(o_mst_stop_req, {NM{1'b0}})
    @(posedge i_clk_sys);
    i_allow_very_low_power <= 1'b1;
    hold <= 1'b1;
    sleep(1'b1, `PMC_STOP_MODE_SELECT_NORMAL);
    wake(2'h0, `PMC_ST_RUN);
    `CHK(o_stop_aborted_flag, 1'b1)
    hold <= 1'b0;
    sleep(1'b1, `PMC_STOP_MODE_SELECT_NORMAL);
    wait_for(`PMC_ST_STOP, 1'b0);
    `CHK(o_stop_aborted_flag, 1'b0)
    wake(2'h0, `PMC_ST_RUN);
    // Interrupt while the regulator heads for stop regulation
    sleep(1'b1, `PMC_STOP_MODE_SELECT_NORMAL);
    for (int n = 0; n < 50 && o_gen_en !== 1'b0; n++)
      @(negedge i_clk_sys);
    wake(2'h0, `PMC_ST_RUN);
    `CHK(o_stop_aborted_flag, 1'b0)
    // Stop entry with the debugger attached, then a halt request
    @(posedge i_clk_sys);
    i_debugger_enabled <= 1'b1;
    sleep(1'b1, `PMC_STOP_MODE_SELECT_NORMAL);
    for (int n = 0; n < 100 && o_reg_run !== 1'b0; n++)
      @(negedge i_clk_sys);
    `CHK(o_cpu_clk_en, 1'b1)
    `CHK(o_bus_clk_en, 1'b0)
    `CHK(o_power_mode_status, `PMC_ST_RUN)
    @(posedge i_clk_sys);
    i_debug_halt <= 1'b1;
    for (int n = 0; n < 100 && o_bus_clk_en !== 1'b1; n++)
      @(negedge i_clk_sys);
    `CHK(o_bus_clk_en, 1'b1)
    `CHK(o_power_mode_status, `PMC_ST_RUN)
    @(posedge i_clk_sys);
    i_debug_halt <= 1'b0;
    i_debugger_enabled <= 1'b0;
    @(posedge i_clk_sys);
    i_run_mode_select <= `PMC_RUN_MODE_SELECT_VERY_LOW_POWER_RUN;
    wait_for(`PMC_ST_VERY_LOW_POWER_RUN, 1'b1);
    `CHK(o_reg_run, 1'b0)
    sleep(1'b0, `PMC_STOP_MODE_SELECT_NORMAL);
    wait_for(`PMC_ST_VERY_LOW_POWER_WAIT, 1'b0);
    `CHK(o_bus_clk_en, 1'b1)
    `CHK(o_stop_in_wait, 1'b1)
    wake(2'h0, `PMC_ST_VERY_LOW_POWER_RUN);
    `CHK(o_stop_in_wait, 1'b0)
    sleep(1'b1, ($urandom_range(0, 1) == 0) ? `PMC_STOP_MODE_SELECT_NORMAL : `PMC_STOP_MODE_SELECT_VERY_LOW_POWER_STOP);
    wait_for(`PMC_ST_VERY_LOW_POWER_STOP, 1'b0);
    wake(2'h0, `PMC_ST_VERY_LOW_POWER_RUN);
    snap = clr_n;
    @(posedge i_clk_sys);
    i_run_mode_select <= `PMC_RUN_MODE_SELECT_RUN;
    wait_for(`PMC_ST_RUN, 1'b1);
    `CHK(o_reg_run, 1'b1)
    sleep(1'b0, 3'($urandom_range(0, 4)));
    wait_for(`PMC_ST_RUN, 1'b0);
    `CHK(o_gen_en, 1'b1)
    wake(2'h0, `PMC_ST_RUN);
    `CHK(clr_n - snap, 1)
    @(posedge i_clk_sys);
    i_run_mode_select <= `PMC_RUN_MODE_SELECT_VERY_LOW_POWER_RUN;
    wait_for(`PMC_ST_VERY_LOW_POWER_RUN, 1'b1);
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    i_run_mode_select <= `PMC_RUN_MODE_SELECT_RUN;
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    wait_for(`PMC_ST_RUN, 1'b1);
    `CHK(o_reg_run, 1'b1)
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule // tb_top
